// ===== hdl/ctrl_latch.sv
/*
 * Enable latch fed from the shared latch inputs, with a fixed bit mapping.
 * Assumes open, clear and shared inputs are already synchronised to clk_i.
 */
`timescale 1ns/1ps
`include "tx_ctrl_consts.svh"

module ctrl_latch #(
    parameter int OUT_W = `NUM_DRV,
    parameter logic [OUT_W*`MAP_IDX_W-1:0] MAP = `DRV_MAP_DEFAULT,
    parameter logic [OUT_W-1:0] RESET_VAL = `DRV_EN_RESET,
    parameter bit CLEAR_WHEN_OPEN = 1'b1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic open_i,
    input wire logic clear_i,
    input wire logic [`SHARED_W-1:0] shared_i,
    output logic [OUT_W-1:0] latched_o
);
    logic [OUT_W-1:0] mapped;

    genvar i;
    generate
        for (i = 0; i < OUT_W; i++) begin : g_map
            assign mapped[i] = shared_i[MAP[i*`MAP_IDX_W +: `MAP_IDX_W]];
        end
    endgenerate

    // the latch is modelled as a register that follows while open
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            latched_o <= RESET_VAL;
        end else if (clear_i && (CLEAR_WHEN_OPEN || !open_i)) begin
            latched_o <= RESET_VAL;
        end else if (open_i) begin
            latched_o <= mapped;
        end
        // closed and not cleared: no branch taken, the value is held
    end

endmodule // ctrl_latch

// ===== hdl/parity_check.sv
/*
 * Per-channel odd-parity checker on the captured input characters.
 * Assumes characters and the check selection are stable in the clk_i domain.
 */
`timescale 1ns/1ps
`include "tx_ctrl_consts.svh"

module parity_check (
    input wire logic clk_i,
    input wire logic resetn_i,
    input tx_ctrl_pkg::tx_char_t [`NUM_CHAN-1:0] chars_i,
    input tx_ctrl_pkg::parity_sel_t sel_i,
    input wire logic hold_i,
    output logic [`NUM_CHAN-1:0] parity_error_o
);
    import tx_ctrl_pkg::*;

    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHAN; ch++) begin : g_chan
            logic parity_sum;
            // control bits join the sum only when selected
            assign parity_sum = ^{chars_i[ch].data, chars_i[ch].odd_parity,
                                  chars_i[ch].ctrl & {`CTRL_W{sel_i.check_ctrl}}};
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    parity_error_o[ch] <= 1'b0;
                end else if (hold_i || !sel_i.check_data) begin
                    parity_error_o[ch] <= 1'b0;
                end else begin
                    parity_error_o[ch] <= ~parity_sum;
                end
            end
        end
    endgenerate

endmodule // parity_check

// ===== hdl/tx_ctrl_consts.svh
/*
 * Constants for the transmitter device-control block: widths, reset values,
 * three-level pin codes, default bit mappings and the reset settle count.
 * Assumes it is included by the package, the design modules and the verification files.
 */
`ifndef TX_CTRL_CONSTS_SVH
`define TX_CTRL_CONSTS_SVH

`define NUM_CHAN 4
`define NUM_DRV 8
`define SHARED_W 8
`define DATA_W 8
`define CTRL_W 2
`define LVL_W 2
`define MAP_IDX_W 3

`define LVL_CODE_LOW 2'b01
`define LVL_CODE_HIGH 2'b10

`define REF_CLK_PERIOD_NS 20
`define SETTLE_LIMIT_CYCLES 16
`define SETTLE_CNT_W 4
`define SETTLE_CYCLES 4'ha

`define DRV_EN_RESET 8'h00
`define SELFTEST_RESET 4'hf
`define DRV_MAP_DEFAULT 24'hfac688
`define SELFTEST_MAP_DEFAULT 12'h688

`endif

// ===== hdl/tx_ctrl_pkg.sv
/*
 * Types for the transmitter device-control block.
 * Assumes tx_ctrl_consts.svh is on the include path.
 */
`include "tx_ctrl_consts.svh"

package tx_ctrl_pkg;

    typedef enum logic [1:0] {
        LVL_MID = 2'b00,
        LVL_LOW = 2'b01,
        LVL_HIGH = 2'b10
    } tri_level_t;

    typedef enum logic [2:0] {
        RATE_195_400 = 3'b001,
        RATE_400_800 = 3'b010,
        RATE_800_1500 = 3'b100
    } rate_range_t;

    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_SETTLE = 3'b010,
        ST_RUN = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic odd_parity;
        logic [`CTRL_W-1:0] ctrl;
        logic [`DATA_W-1:0] data;
    } tx_char_t;

    typedef struct packed {
        logic check_data;
        logic check_ctrl;
    } parity_sel_t;

    typedef struct packed {
        logic device_reset_n;
        logic input_clock_select;
        logic half_rate_ref_select;
        logic driver_latch_open;
        logic selftest_latch_open;
        logic [`LVL_W-1:0] parity_check_select;
        logic [`LVL_W-1:0] rate_range_select;
        logic [2*`LVL_W-1:0] tx_operating_mode;
        logic [`SHARED_W-1:0] shared_latch_inputs;
    } pin_bundle_t;

    // a floating pin shows neither code, so it reads as mid
    function automatic tri_level_t decode_level(input logic [`LVL_W-1:0] code);
        tri_level_t lvl;
        lvl = LVL_MID;
        if (code == `LVL_CODE_LOW) begin
            lvl = LVL_LOW;
        end else if (code == `LVL_CODE_HIGH) begin
            lvl = LVL_HIGH;
        end
        return lvl;
    endfunction

endpackage

// ===== hdl/tx_device_control.sv
/*
 * Device-level control of a four-channel serial transmitter: three-level
 * static selects, synchronous device reset with settle sequence, parity
 * check of the input register, and the driver and self-test enable latches.
 * Assumes clk_i is the 50 MHz reference clock; all pins other than the
 * character inputs arrive asynchronously and are synchronised here.
 */
`timescale 1ns/1ps
`include "tx_ctrl_consts.svh"

// Notes on behaviour
// - parity select low: no parity check on any channel.
// - mid with encoder on: data plus parity bit checked for odd parity.
// - mid with encoder bypassed: data, control and parity bit checked odd.
// - parity select high: data, control and parity bit always checked odd.
// - rate select low, mid, high picks 195-400, 400-800, 800-1500 MBd.
// - reset sampled low on clock edge initialises all state and counters.
// - after reset release outputs settle in fewer than 16 clock cycles.
// - input clock select low: reference clock captures the input data.
// - driver latch open: shared inputs drive the serial driver enables.
// - enable bit high turns its driver on; low powers it down.
// - driver latch closing holds the last shared input values.
// - device reset clears the driver latch, disabling every driver.
// - self-test latch open: shared inputs drive the self-test enables.
// - self-test bit low runs the test pattern; high sends normal data.
// - self-test latch closing holds the last shared input values.
// - reset with self-test latch closed disables self-test everywhere.
// - a floating three-level select reads as mid level.
module tx_device_control #(
    parameter logic [`NUM_DRV*`MAP_IDX_W-1:0] DRV_MAP = `DRV_MAP_DEFAULT,
    parameter logic [`NUM_CHAN*`MAP_IDX_W-1:0] SELFTEST_MAP = `SELFTEST_MAP_DEFAULT
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic device_reset_n_i,
    input wire logic input_clock_select_i,
    input wire logic half_rate_ref_select_i,
    input wire logic [`LVL_W-1:0] parity_check_select_i,
    input wire logic [`LVL_W-1:0] rate_range_select_i,
    input wire logic [2*`LVL_W-1:0] tx_operating_mode_i,
    input wire logic driver_enable_latch_open_i,
    input wire logic selftest_latch_open_i,
    input wire logic [`SHARED_W-1:0] shared_latch_inputs_i,
    input tx_ctrl_pkg::tx_char_t [`NUM_CHAN-1:0] char_in_i,
    output logic [`NUM_DRV-1:0] serial_out_driver_en_o,
    output logic [`NUM_CHAN-1:0] selftest_enable_n_o,
    output logic [`NUM_CHAN-1:0] parity_error_o,
    output tx_ctrl_pkg::rate_range_t rate_range_o,
    output logic rate_combo_invalid_o,
    output logic ref_clocks_input_o,
    output logic outputs_ready_o
);
    import tx_ctrl_pkg::*;

    pin_bundle_t pins;
    pin_bundle_t pins_meta_r;
    pin_bundle_t pins_r;
    tri_level_t par_lvl;
    tri_level_t spd_lvl;
    tri_level_t mode_hi_lvl;
    logic dev_rst_active;
    logic encoder_on;
    parity_sel_t par_sel;
    tx_char_t [`NUM_CHAN-1:0] chars_r;
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [`SETTLE_CNT_W-1:0] settle_r;
    logic [`SETTLE_CNT_W-1:0] settle_nxt;
    rate_range_t rate_nxt;

    assign pins.device_reset_n = device_reset_n_i;
    assign pins.input_clock_select = input_clock_select_i;
    assign pins.half_rate_ref_select = half_rate_ref_select_i;
    assign pins.driver_latch_open = driver_enable_latch_open_i;
    assign pins.selftest_latch_open = selftest_latch_open_i;
    assign pins.parity_check_select = parity_check_select_i;
    assign pins.rate_range_select = rate_range_select_i;
    assign pins.tx_operating_mode = tx_operating_mode_i;
    assign pins.shared_latch_inputs = shared_latch_inputs_i;

    // two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pins_meta_r <= '0;
            pins_r <= '0;
        end else begin
            pins_meta_r <= pins;
            pins_r <= pins_meta_r;
        end
    end

    // device reset is a level sampled on the reference clock edge
    assign dev_rst_active = !pins_r.device_reset_n;

    assign par_lvl = decode_level(pins_r.parity_check_select);
    assign spd_lvl = decode_level(pins_r.rate_range_select);
    assign mode_hi_lvl = decode_level(pins_r.tx_operating_mode[2*`LVL_W-1:`LVL_W]);
    assign encoder_on = (mode_hi_lvl != LVL_LOW);

    always_comb begin
        par_sel.check_data = 1'b0;
        par_sel.check_ctrl = 1'b0;
        case (par_lvl)
            LVL_LOW: begin
                par_sel.check_data = 1'b0;
            end
            LVL_MID: begin
                par_sel.check_data = 1'b1;
                par_sel.check_ctrl = !encoder_on;
            end
            LVL_HIGH: begin
                par_sel.check_data = 1'b1;
                par_sel.check_ctrl = 1'b1;
            end
            default: begin
                par_sel.check_data = 1'b0;
            end
        endcase
    end

    // input register on the reference clock; other input clocks are not built here
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chars_r <= '0;
        end else if (dev_rst_active) begin
            chars_r <= '0;
        end else begin
            chars_r <= char_in_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ref_clocks_input_o <= 1'b0;
        end else begin
            ref_clocks_input_o <= !pins_r.input_clock_select;
        end
    end

    always_comb begin
        case (spd_lvl)
            LVL_LOW: begin
                rate_nxt = RATE_195_400;
            end
            LVL_HIGH: begin
                rate_nxt = RATE_800_1500;
            end
            default: begin
                rate_nxt = RATE_400_800;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rate_range_o <= RATE_400_800;
        end else begin
            rate_range_o <= rate_nxt;
        end
    end

    // flagged only; the host is the one that must avoid this pairing
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rate_combo_invalid_o <= 1'b0;
        end else begin
            rate_combo_invalid_o <= (spd_lvl == LVL_LOW) && pins_r.half_rate_ref_select;
        end
    end

    // reset sequencer: settle count keeps data outputs quiet until defined
    always_comb begin
        state_nxt = state_r;
        settle_nxt = settle_r;
        case (state_r)
            ST_RESET: begin
                settle_nxt = '0;
                if (!dev_rst_active) begin
                    state_nxt = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                settle_nxt = settle_r + `SETTLE_CNT_W'(1);
                if (settle_r == `SETTLE_CYCLES - `SETTLE_CNT_W'(1)) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                settle_nxt = '0;
            end
            default: begin
                state_nxt = ST_RESET;
                settle_nxt = '0;
            end
        endcase
        if (dev_rst_active) begin
            state_nxt = ST_RESET;
            settle_nxt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_RESET;
            settle_r <= '0;
        end else begin
            state_r <= state_nxt;
            settle_r <= settle_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            outputs_ready_o <= 1'b0;
        end else begin
            outputs_ready_o <= (state_nxt == ST_RUN);
        end
    end

    parity_check u_parity (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .chars_i(chars_r),
        .sel_i(par_sel),
        .hold_i(!outputs_ready_o),
        .parity_error_o(parity_error_o)
    );

    // driver enables: a high bit turns the driver on, reset clears even when open
    ctrl_latch #(
        .OUT_W(`NUM_DRV),
        .MAP(DRV_MAP),
        .RESET_VAL(`DRV_EN_RESET),
        .CLEAR_WHEN_OPEN(1'b1)
    ) u_drv_latch (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .open_i(pins_r.driver_latch_open),
        .clear_i(dev_rst_active),
        .shared_i(pins_r.shared_latch_inputs),
        .latched_o(serial_out_driver_en_o)
    );

    // self-test enables are active low; reset only clears a closed latch
    ctrl_latch #(
        .OUT_W(`NUM_CHAN),
        .MAP(SELFTEST_MAP),
        .RESET_VAL(`SELFTEST_RESET),
        .CLEAR_WHEN_OPEN(1'b0)
    ) u_selftest_latch (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .open_i(pins_r.selftest_latch_open),
        .clear_i(dev_rst_active),
        .shared_i(pins_r.shared_latch_inputs),
        .latched_o(selftest_enable_n_o)
    );

    // helper for the checks below: the mapped shared inputs
    logic [`NUM_DRV-1:0] drv_expect;
    logic [`NUM_CHAN-1:0] st_expect;
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_DRV; gi++) begin : g_drv_exp
            assign drv_expect[gi] =
                pins_r.shared_latch_inputs[DRV_MAP[gi*`MAP_IDX_W +: `MAP_IDX_W]];
        end
        for (gi = 0; gi < `NUM_CHAN; gi++) begin : g_st_exp
            assign st_expect[gi] =
                pins_r.shared_latch_inputs[SELFTEST_MAP[gi*`MAP_IDX_W +: `MAP_IDX_W]];
        end
    endgenerate

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    chk_parity_off_low:
    assert property ((par_lvl == LVL_LOW) |=> (parity_error_o == '0))
        else $error("parity error raised with parity check off");

    chk_parity_mid_enc:
    assert property ((par_lvl == LVL_MID) && encoder_on && outputs_ready_o
                     ##0 (state_nxt == ST_RUN)
                     |=> parity_error_o[0] ==
                         $past(~^{chars_r[0].data, chars_r[0].odd_parity}))
        else $error("mid level with encoder on checked the wrong bits");

    chk_parity_mid_bypass:
    assert property ((par_lvl == LVL_MID) && !encoder_on && outputs_ready_o
                     && (state_nxt == ST_RUN)
                     |=> parity_error_o[0] ==
                         $past(~^{chars_r[0].data, chars_r[0].ctrl, chars_r[0].odd_parity}))
        else $error("mid level with encoder bypassed checked the wrong bits");

    chk_parity_high_all:
    assert property ((par_lvl == LVL_HIGH) && outputs_ready_o && (state_nxt == ST_RUN)
                     && (^chars_r[1] == 1'b0) |=> parity_error_o[1])
        else $error("even parity missed with parity check high");

    chk_rate_range_map:
    assert property ((spd_lvl == LVL_HIGH) |=> (rate_range_o == RATE_800_1500))
        else $error("high rate select did not pick the top range");

    chk_rate_low_map:
    assert property ($changed(spd_lvl) && (spd_lvl == LVL_LOW)
                     |=> (rate_range_o == RATE_195_400) [*2])
        else $error("low rate select did not pick the bottom range");

    chk_reset_inits:
    assert property (dev_rst_active |=> (state_r == ST_RESET) && !outputs_ready_o
                     && (settle_r == '0))
        else $error("device reset did not initialise the sequencer");

    chk_settle_bound:
    assert property ($fell(dev_rst_active) |-> !dev_rst_active throughout
                     (##[1:13] outputs_ready_o) or ##[1:13] dev_rst_active)
        else $error("outputs not ready within the settle bound");

    chk_ready_not_early:
    assert property ($fell(dev_rst_active) |-> !outputs_ready_o [*8])
        else $error("outputs ready too soon after reset release");

    chk_drv_transparent:
    assert property (pins_r.driver_latch_open && !dev_rst_active
                     |=> serial_out_driver_en_o == $past(drv_expect))
        else $error("open driver latch did not follow shared inputs");

    chk_drv_hold:
    assert property (!pins_r.driver_latch_open && !dev_rst_active
                     |=> $stable(serial_out_driver_en_o))
        else $error("closed driver latch changed");

    chk_drv_reset_clear:
    assert property (dev_rst_active |=> (serial_out_driver_en_o == `DRV_EN_RESET))
        else $error("device reset left a serial driver enabled");

    chk_st_transparent:
    assert property (pins_r.selftest_latch_open && !dev_rst_active
                     |=> selftest_enable_n_o == $past(st_expect))
        else $error("open self-test latch did not follow shared inputs");

    chk_st_hold:
    assert property (!pins_r.selftest_latch_open && !dev_rst_active
                     |=> $stable(selftest_enable_n_o))
        else $error("closed self-test latch changed");

    chk_st_reset_clear:
    assert property (dev_rst_active && !pins_r.selftest_latch_open
                     |=> (selftest_enable_n_o == `SELFTEST_RESET))
        else $error("reset with closed latch left self-test running");

    chk_combo_flag:
    assert property ((spd_lvl == LVL_LOW) && pins_r.half_rate_ref_select
                     |=> rate_combo_invalid_o)
        else $error("invalid rate and half-rate pairing not flagged");

endmodule // tx_device_control

// ===== verification/host_model.sv
/*
 * Host-side model that drives the static selects, the device reset, the latch
 * pins and the character inputs of the transmitter control block.
 * Assumes the testbench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps
`include "tx_ctrl_consts.svh"

module host_model (
    output logic device_reset_n_o,
    output logic input_clock_select_o,
    output logic half_rate_ref_select_o,
    output logic [`LVL_W-1:0] parity_check_select_o,
    output logic [`LVL_W-1:0] rate_range_select_o,
    output logic [2*`LVL_W-1:0] tx_operating_mode_o,
    output logic driver_enable_latch_open_o,
    output logic selftest_latch_open_o,
    output logic [`SHARED_W-1:0] shared_latch_inputs_o,
    output tx_ctrl_pkg::tx_char_t [`NUM_CHAN-1:0] char_in_o
);
    import tx_ctrl_pkg::*;

    // power-up with device reset held, so the reset sequencer and settle count start clean
    initial begin
        device_reset_n_o = 1'b0;
        input_clock_select_o = 1'b0;
        half_rate_ref_select_o = 1'b0;
        parity_check_select_o = 2'b00;
        rate_range_select_o = 2'b00;
        tx_operating_mode_o = 4'h0;
        driver_enable_latch_open_o = 1'b0;
        selftest_latch_open_o = 1'b0;
        shared_latch_inputs_o = 8'hff;
        char_in_o = '0;
    end

    task automatic set_statics(input logic [1:0] par, input logic [1:0] rate,
                               input logic [3:0] mode, input logic ics, input logic hr);
        parity_check_select_o = par;
        rate_range_select_o = rate;
        tx_operating_mode_o = mode;
        input_clock_select_o = ics;
        // half-rate reference never offered with the low rate range
        half_rate_ref_select_o = (rate == `LVL_CODE_LOW) ? 1'b0 : hr;
    endtask

    task automatic set_latches(input logic drv_open, input logic st_open,
                               input logic [7:0] shared);
        driver_enable_latch_open_o = drv_open;
        selftest_latch_open_o = st_open;
        shared_latch_inputs_o = shared;
    endtask

    task automatic set_reset(input logic n);
        device_reset_n_o = n;
    endtask

    task automatic send_chars(input tx_char_t [`NUM_CHAN-1:0] c);
        char_in_o = c;
    endtask
endmodule // host_model

// ===== verification/tx_device_control_tb.sv
/*
 * Self-checking bench for the transmitter device-control block.
 * Assumes the host model drives every pin other than clk_i and resetn_i and outputs settle 3 edges after a pin change.
 */
`timescale 1ns/1ps
`include "tx_ctrl_consts.svh"

module tx_device_control_tb;
    import tx_ctrl_pkg::*;

    // non-identity mappings with repeated indices, so a hard-wired identity map would be caught
    localparam logic [23:0] DRV_MAP_T = 24'h1c6b2e;
    localparam logic [11:0] ST_MAP_T = 12'h9e3;

    logic clk_i;
    logic resetn_i;
    logic device_reset_n, ics, hr, drv_open, st_open;
    logic [1:0] par_sel, rate_sel;
    logic [3:0] op_mode;
    logic [7:0] shared;
    tx_char_t [3:0] chars;
    logic [7:0] drv_en;
    logic [3:0] st_en_n, par_err;
    rate_range_t rate_out;
    logic combo_bad, ref_in, ready;
    int n_mismatch;
    int tests_run;

    host_model host (
        .device_reset_n_o(device_reset_n), .input_clock_select_o(ics),
        .half_rate_ref_select_o(hr), .parity_check_select_o(par_sel),
        .rate_range_select_o(rate_sel), .tx_operating_mode_o(op_mode),
        .driver_enable_latch_open_o(drv_open), .selftest_latch_open_o(st_open),
        .shared_latch_inputs_o(shared), .char_in_o(chars)
    );

    tx_device_control #(.DRV_MAP(DRV_MAP_T), .SELFTEST_MAP(ST_MAP_T)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .device_reset_n_i(device_reset_n),
        .input_clock_select_i(ics), .half_rate_ref_select_i(hr),
        .parity_check_select_i(par_sel), .rate_range_select_i(rate_sel),
        .tx_operating_mode_i(op_mode), .driver_enable_latch_open_i(drv_open),
        .selftest_latch_open_i(st_open), .shared_latch_inputs_i(shared),
        .char_in_i(chars), .serial_out_driver_en_o(drv_en), .selftest_enable_n_o(st_en_n),
        .parity_error_o(par_err), .rate_range_o(rate_out), .rate_combo_invalid_o(combo_bad),
        .ref_clocks_input_o(ref_in), .outputs_ready_o(ready)
    );

    always #10 clk_i = ~clk_i;

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // inputs always move 2 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    function automatic logic [7:0] map_bits(input logic [7:0] sh, input logic [23:0] m,
                                            input int w);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < w; i++) begin
            r[i] = sh[m[3*i+:3]];
        end
        return r;
    endfunction

    function automatic rate_range_t exp_rate(input logic [1:0] code);
        if (code == `LVL_CODE_LOW) return RATE_195_400;
        if (code == `LVL_CODE_HIGH) return RATE_800_1500;
        return RATE_400_800;
    endfunction

    function automatic logic [3:0] exp_par(input tx_char_t [3:0] c, input logic [1:0] ps,
                                           input logic [1:0] m1);
        logic [3:0] e;
        logic incl;
        e = 4'h0;
        incl = (ps == `LVL_CODE_HIGH) || (m1 == `LVL_CODE_LOW);
        if (ps != `LVL_CODE_LOW) begin
            for (int i = 0; i < 4; i++) begin
                e[i] = ~(^c[i].data ^ c[i].odd_parity ^ (incl & (^c[i].ctrl)));
            end
        end
        return e;
    endfunction

    // ready must come back within the settle bound; a hang ends the run
    task automatic wait_ready;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        if (n >= 40) begin
            n_mismatch++;
            complete_run();
        end else begin
            check(n < 16, 1);
        end
    endtask

    initial begin
        logic [7:0] x;
        logic [1:0] codes [4];
        logic [1:0] m1;
        tx_char_t [3:0] p1, p2, nc;
        clk_i = 1'b0;
        resetn_i = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        codes = '{2'b01, 2'b00, 2'b10, 2'b11};
        void'($urandom(82));
        step(4);
        check(drv_en, `DRV_EN_RESET);
        check(st_en_n, `SELFTEST_RESET);
        check({par_err, rate_out, ready}, {4'h0, RATE_400_800, 1'b0});
        resetn_i = 1'b1;
        step(2);
        host.set_reset(1'b1);
        wait_ready();
        $display("test reset_release done");

        for (int k = 0; k < 2; k++) begin
            x = 8'($urandom);
            host.set_latches(k == 0, k == 1, x);
            step(4);
            for (int ph = 0; ph < 3; ph++) begin
                if (k == 0) check(drv_en, map_bits(x, DRV_MAP_T, 8));
                else check(st_en_n, map_bits(x, {12'h000, ST_MAP_T}, 4));
                if (ph == 0) begin
                    x = ~x;
                    host.set_latches(k == 0, k == 1, x);
                    step(4);
                end else if (ph == 1) begin
                    host.set_latches(1'b0, 1'b0, x);
                    step(1);
                    host.set_latches(1'b0, 1'b0, ~x);
                    step(4);
                end
            end
        end
        $display("test latches done");

        host.set_latches(1'b1, 1'b1, 8'ha5);
        step(4);
        host.set_latches(1'b0, 1'b0, 8'ha5);
        step(4);
        host.set_reset(1'b0);
        step(4);
        check({drv_en, st_en_n, ready}, {8'h00, 4'hf, 1'b0});
        host.set_reset(1'b1);
        wait_ready();
        check({drv_en, st_en_n}, {8'h00, 4'hf});
        $display("test device_reset done");

        for (int a = 0; a < 4; a++) begin
            for (int b = 0; b < 3; b++) begin
                m1 = codes[b];
                host.set_statics(codes[a], codes[a], {m1, 2'($urandom)}, 1'(a), 1'($urandom));
                step(4);
                check(rate_out, exp_rate(codes[a]));
                check(combo_bad, (codes[a] == `LVL_CODE_LOW) & hr);
                check(ref_in, !ics);
                for (int j = 0; j < 22; j++) begin
                    if (j >= 2) check(par_err, exp_par(p2, codes[a], m1));
                    nc = (j == 0) ? '0 : 44'({$urandom, $urandom});
                    p2 = p1;
                    p1 = nc;
                    host.send_chars(nc);
                    step(1);
                end
            end
        end
        $display("test statics_parity done");
        complete_run();
    end
endmodule // tx_device_control_tb
